// File: logic/dacp_pkg.sv
// Constants and types shared by the converter configuration port
package dacp_pkg;
  localparam int unsigned SYNC_WIDTH      = 7;
  localparam int unsigned CODE_WIDTH      = 16;
  localparam int unsigned WORD_BITS       = 16;
  localparam logic [4:0]  BIT_CNT_HDR     = 5'h08;
  localparam logic [4:0]  BIT_CNT_END     = 5'h10;
  localparam int unsigned RW_POS          = 15;
  localparam int unsigned ADDR_MSB        = 14;
  localparam int unsigned ADDR_LSB        = 8;
  localparam int unsigned REG_COUNT       = 4;
  localparam logic [6:0]  ADDR_POWER      = 7'h00;
  localparam logic [6:0]  ADDR_TIMING     = 7'h01;
  localparam logic [6:0]  ADDR_FORMAT     = 7'h02;
  localparam logic [6:0]  ADDR_SPARE      = 7'h03;
  localparam int unsigned PD_LSB          = 0;
  localparam int unsigned DCS_POS         = 0;
  localparam int unsigned TWOS_POS        = 0;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [1:0]  PD_NORMAL       = 2'h0;
  localparam logic [CODE_WIDTH-1:0] CODE_MSB_MASK = 16'h8000;
  // Sync vector bit positions
  localparam int unsigned S_CS = 0;
  localparam int unsigned S_SCK = 1;
  localparam int unsigned S_SDI = 2;
  localparam int unsigned S_SDO = 3;
  localparam int unsigned S_ENCP = 4;
  localparam int unsigned S_ENCN = 5;
  localparam int unsigned S_STRAP = 6;
  typedef logic [7:0] dacp_reg_type;
endpackage

// File: logic/dacp_sync.sv
// Two-flop synchroniser for the asynchronous port pins
`timescale 1ns/1ps
`default_nettype none
module dacp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: logic/dacp_config_port.sv
// Configuration port and encode control of a two-channel sampling converter
//
// Notes on behaviour
// [R1] A conversion starts on each rising edge of the positive encode input, sampling both channels; the code starts none unless pd_mode is PD_NORMAL.
// [R2] A falling edge on the complementary encode input also marks the start, as a differential pair.
// [R3] With the mode strap low, the four port pins act as a serial interface to the mode registers.
// [R4] With the mode strap high, the four port pins are static inputs selecting a reduced mode set.
// [R5] In serial mode, data shifts into the mode registers only while chip select is low.
// [R6] Each data-in bit is captured on the rising serial clock; the controller sets it up beforehand.
// [R7] On readback, register bits leave on the data output and the controller samples on the falling clock.
// [R8] The data output is open drain: pulled low for a zero, released for a one.
// [R9] In parallel mode, the chip select level enables or disables the duty cycle stabilizer.
// [R10] In parallel mode, the serial clock level selects the output format.
// [R11] In parallel mode, data in and data out levels together choose the power-down state.
// [R12] In two's complement format, just below zero reads all ones and just above zero all zeros.
// [R13] Serial clock edges are ignored while chip select is high; framing restarts at each low period.
`timescale 1ns/1ps
`default_nettype none
module dacp_config_port
  import dacp_pkg::*;
(
  input  wire logic                            clk,
  input  wire logic                            reset,
  input  wire logic                            prog_mode_strap,
  input  wire logic                            cs_n,
  input  wire logic                            sck,
  input  wire logic                            sdi,
  input  wire logic                            sdo_i,
  output var  logic                            sdo_o,
  output var  logic                            sdo_oe_n,
  input  wire logic                            enc_p,
  input  wire logic                            enc_n,
  input  wire logic [dacp_pkg::CODE_WIDTH-1:0] ch1_code,
  input  wire logic [dacp_pkg::CODE_WIDTH-1:0] ch2_code,
  output var  logic                            enc_start,
  output var  logic [dacp_pkg::CODE_WIDTH-1:0] ch1_data,
  output var  logic [dacp_pkg::CODE_WIDTH-1:0] ch2_data,
  output var  logic                            serial_mode,
  output var  logic                            dcs_en,
  output var  logic                            twos_comp,
  output var  logic [1:0]                      pd_mode
);
  import dacp_pkg::*;

  logic [SYNC_WIDTH-1:0] pins_s;
  logic                  sck_prev_q;
  logic                  enc_prev_q;
  logic                  enc_diff;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  par_mode;
  logic                  frame_on;
  logic [4:0]            bit_cnt_q;
  logic [WORD_BITS-1:0]  shift_in_q;
  logic [7:0]            shift_out_q;
  logic                  read_q;
  dacp_reg_type          regs_q [REG_COUNT];
  logic [WORD_BITS-1:0]  word_next;

  // Offset binary to output format; MSB flip gives two's complement
  function automatic logic [CODE_WIDTH-1:0] fmt_code(input logic [CODE_WIDTH-1:0] c,
                                                    input logic twos);
    fmt_code = twos ? (c ^ CODE_MSB_MASK) : c;
  endfunction

  // Register index from an address, out-of-range reads the spare slot
  function automatic logic [1:0] reg_index(input logic [6:0] a);
    reg_index = (a < 7'(REG_COUNT)) ? a[1:0] : ADDR_SPARE[1:0];
  endfunction

  // All pins come from outside the clock domain
  dacp_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({prog_mode_strap, enc_n, enc_p, sdo_i, sdi, sck, cs_n}),
    .sync_out (pins_s)
  );

  // Edge and mode decode
  assign enc_diff  = pins_s[S_ENCP] & ~pins_s[S_ENCN]; // see [R2]
  assign sck_rise  = pins_s[S_SCK] & ~sck_prev_q;
  assign sck_fall  = ~pins_s[S_SCK] & sck_prev_q;
  assign par_mode  = pins_s[S_STRAP];
  assign frame_on  = ~par_mode & ~pins_s[S_CS]; // see [R3] see [R5] see [R13]
  assign word_next = {shift_in_q[WORD_BITS-2:0], pins_s[S_SDI]};

  // Previous samples for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      sck_prev_q <= 1'b0;
      enc_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= pins_s[S_SCK];
      enc_prev_q <= enc_diff;
    end
  end

  // Conversion start captures both channels together
  always_ff @(posedge clk) begin
    if (reset) begin
      enc_start <= 1'b0;
      ch1_data  <= '0;
      ch2_data  <= '0;
    end else begin
      enc_start <= 1'b0;
      if (enc_diff && !enc_prev_q && pd_mode == PD_NORMAL) begin // see [R1] see [R2]
        enc_start <= 1'b1;
        ch1_data  <= fmt_code(ch1_code, twos_comp); // see [R12]
        ch2_data  <= fmt_code(ch2_code, twos_comp);
      end
    end
  end

  // Bit framing, restarted whenever chip select is high
  always_ff @(posedge clk) begin
    if (reset || !frame_on) begin
      bit_cnt_q  <= '0; // see [R13]
      shift_in_q <= '0;
    end else if (sck_rise && bit_cnt_q < BIT_CNT_END) begin
      bit_cnt_q  <= bit_cnt_q + 5'h01; // see [R6]
      shift_in_q <= word_next;
    end
  end

  // Readback shifter, loaded after the header and advanced on falling clock
  always_ff @(posedge clk) begin
    if (reset || !frame_on) begin
      read_q      <= 1'b0;
      shift_out_q <= '1;
    end else if (sck_rise && bit_cnt_q == BIT_CNT_HDR - 5'h01) begin
      read_q      <= word_next[RW_POS-ADDR_LSB];
      shift_out_q <= regs_q[reg_index(word_next[ADDR_MSB-ADDR_LSB:0])];
    end else if (sck_fall && read_q && bit_cnt_q >= BIT_CNT_HDR) begin
      shift_out_q <= {shift_out_q[6:0], 1'b1}; // see [R7]
    end
  end

  // Open-drain data out: enable low only to pull a zero
  always_ff @(posedge clk) begin
    if (reset) begin
      sdo_o    <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_o    <= 1'b0; // see [R8]
      sdo_oe_n <= ~(frame_on && read_q && bit_cnt_q >= BIT_CNT_HDR && !shift_out_q[7]);
    end
  end

  // Mode registers written at the end of a sixteen-bit write word
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (frame_on && sck_rise && bit_cnt_q == BIT_CNT_END - 5'h01
                 && !shift_in_q[RW_POS-1]) begin // see [R5]
      regs_q[reg_index(word_next[ADDR_MSB:ADDR_LSB])] <= word_next[7:0];
    end
  end

  // Effective modes: strap picks static pins or programmed registers
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_mode <= 1'b0;
      dcs_en      <= 1'b0;
      twos_comp   <= 1'b0;
      pd_mode     <= PD_NORMAL;
    end else if (par_mode) begin
      serial_mode <= 1'b0; // see [R4]
      dcs_en      <= pins_s[S_CS]; // see [R9]
      twos_comp   <= pins_s[S_SCK]; // see [R10]
      pd_mode     <= {pins_s[S_SDI], pins_s[S_SDO]}; // see [R11]
    end else begin
      serial_mode <= 1'b1; // see [R3]
      dcs_en      <= regs_q[ADDR_TIMING[1:0]][DCS_POS];
      twos_comp   <= regs_q[ADDR_FORMAT[1:0]][TWOS_POS];
      pd_mode     <= regs_q[ADDR_POWER[1:0]][PD_LSB+1:PD_LSB];
    end
  end

  property p_enc_start;
    @(posedge clk) disable iff (reset)
      (enc_diff && !enc_prev_q && pd_mode == PD_NORMAL) |=> enc_start;
  endproperty
  a_enc_start: assert property (p_enc_start) else $error("missed conversion start"); // see [R1]

  property p_enc_pair;
    @(posedge clk) disable iff (reset)
      enc_start |-> $past(enc_diff) && !$past(enc_prev_q) && !$past(pins_s[S_ENCN]);
  endproperty
  a_enc_pair: assert property (p_enc_pair) else $error("start without encode edge"); // see [R2]

  property p_cs_idle;
    @(posedge clk) disable iff (reset)
      (!par_mode && pins_s[S_CS]) |=> bit_cnt_q == 5'h00;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("framing not restarted"); // see [R13]

  property p_shift;
    @(posedge clk) disable iff (reset)
      (frame_on && sck_rise && bit_cnt_q < BIT_CNT_END)
        |=> bit_cnt_q == $past(bit_cnt_q) + 5'h01 && shift_in_q[0] == $past(pins_s[S_SDI]);
  endproperty
  a_shift: assert property (p_shift) else $error("data bit not captured"); // see [R6]

  property p_no_shift_par;
    @(posedge clk) disable iff (reset)
      par_mode |=> bit_cnt_q == 5'h00 && !serial_mode;
  endproperty
  a_no_shift_par: assert property (p_no_shift_par) else $error("shifting in parallel mode"); // see [R5]

  // Outside a frame the line is released, and the output value never drives high
  property p_sdo_od;
    @(posedge clk) disable iff (reset)
      !frame_on |=> sdo_oe_n && !sdo_o;
  endproperty
  a_sdo_od: assert property (p_sdo_od) else $error("data out driven high or idle"); // see [R8]

  property p_readback;
    @(posedge clk) disable iff (reset)
      (frame_on && read_q && bit_cnt_q >= BIT_CNT_HDR && !sck_fall) ##1 frame_on
        |-> sdo_oe_n == $past(shift_out_q[7]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback bit wrong"); // see [R7]

  property p_par_modes;
    @(posedge clk) disable iff (reset)
      par_mode |=> dcs_en == $past(pins_s[S_CS]) && twos_comp == $past(pins_s[S_SCK])
                   && pd_mode == {$past(pins_s[S_SDI]), $past(pins_s[S_SDO])};
  endproperty
  a_par_modes: assert property (p_par_modes) else $error("parallel mode pins not applied"); // see [R9]

  property p_twos;
    @(posedge clk) disable iff (reset)
      (enc_diff && !enc_prev_q && pd_mode == PD_NORMAL && twos_comp && ch1_code == 16'h7fff)
        |=> ch1_data == 16'hffff;
  endproperty
  a_twos: assert property (p_twos) else $error("below zero not all ones"); // see [R12]
endmodule
`default_nettype wire

// File: sim/dacp_host_model.sv
// Serial controller model that programs and reads back the mode registers
`timescale 1ns/1ps
`default_nettype none
module dacp_host_model (
  input  wire logic clk,
  input  wire logic sdo_line,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic sdi
);
  localparam int HALF = 13;
  // Idle pins: deselected, clock low
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b1;
  end
  // Waits whole clocks, then steps just past the edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Static levels for parallel mode or stray edges
  task automatic set_pins(input logic c, input logic k, input logic d);
    wait_clk(1);
    cs_n = c;
    sck = k;
    sdi = d;
  endtask
  // One frame, MSB first; fewer than 16 bits aborts it
  task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    wait_clk(1);
    cs_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi = w[i];
      wait_clk(HALF);
      sck = 1'b1;
      wait_clk(HALF);
      if (i >= 1 && i <= 8) rd[i-1] = sdo_line;
      sck = 1'b0;
    end
    wait_clk(HALF);
    cs_n = 1'b1;
    wait_clk(HALF);
  endtask
endmodule
`default_nettype wire

// File: sim/tb_dual_adc_config_port.sv
// Self-checking bench of the converter configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_dual_adc_config_port;
  import dacp_pkg::*;
  logic        clk = 1'b0;
  logic        reset;
  logic        strap;
  logic        enc_p;
  logic        enc_n;
  logic        sdo_drv;
  logic [15:0] c1;
  logic [15:0] c2;
  logic        cs_n, sck, sdi, sdo_o, sdo_oe_n, st, ser, dcs, twos;
  logic [15:0] d1, d2;
  logic [1:0]  pd;
  logic [7:0]  d;
  wire         sdo_pin;
  int          n_mismatch = 0;
  int          compares = 0;
  // Pull-up on the open-drain line; bench may pull it low in parallel mode
  assign sdo_pin = sdo_drv & (sdo_oe_n | sdo_o);
  always #5 clk = ~clk;
  dacp_host_model u_host (.clk(clk), .sdo_line(sdo_pin), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  dacp_config_port u_dut (.clk(clk), .reset(reset), .prog_mode_strap(strap), .cs_n(cs_n),
    .sck(sck), .sdi(sdi), .sdo_i(sdo_pin), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .enc_p(enc_p),
    .enc_n(enc_n), .ch1_code(c1), .ch2_code(c2), .enc_start(st), .ch1_data(d1), .ch2_data(d2),
    .serial_mode(ser), .dcs_en(dcs), .twos_comp(twos), .pd_mode(pd));
  // Compare helpers
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({15'h0, got}, {15'h0, exp});
  endtask
  task automatic conclude();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    u_host.xfer({1'b0, a, v}, 16, d);
  endtask
  // Drives the encode pair, then watches a bounded span for a start pulse
  task automatic enc_step(input logic p, input logic n, input logic exp);
    logic seen;
    seen = 1'b0;
    u_host.wait_clk(1);
    enc_p = p;
    enc_n = n;
    repeat (8) begin
      u_host.wait_clk(1);
      if (st === 1'b1) seen = 1'b1;
    end
    chk_flag(seen, exp);
  endtask
  task automatic t_serial();
    chk_flag(ser, 1'b1);
    chk_flag(sdo_oe_n, 1'b1);
    wr(ADDR_SPARE, 8'h5a);
    u_host.xfer({1'b1, ADDR_SPARE, 8'h00}, 16, d);
    chk_word({8'h0, d}, 16'h005a);
    wr(ADDR_TIMING, 8'h01);
    wr(ADDR_FORMAT, 8'h01);
    chk_flag(dcs, 1'b1);
    chk_flag(twos, 1'b1);
    $display("test serial done");
  endtask
  task automatic t_abort();
    u_host.xfer({1'b0, ADDR_SPARE, 8'hff}, 10, d);
    repeat (4) begin
      u_host.set_pins(1'b1, 1'b1, 1'b1);
      u_host.wait_clk(8);
      u_host.set_pins(1'b1, 1'b0, 1'b0);
      u_host.wait_clk(8);
    end
    u_host.xfer({1'b1, ADDR_SPARE, 8'h00}, 16, d);
    chk_word({8'h0, d}, 16'h005a);
    $display("test abort done");
  endtask
  task automatic t_encode();
    c1 = 16'h7fff;
    c2 = 16'h8000;
    enc_step(1'b1, 1'b0, 1'b1);
    chk_word(d1, 16'hffff);
    chk_word(d2, 16'h0000);
    c1 = 16'h1234;
    c2 = 16'hfedc;
    enc_step(1'b0, 1'b0, 1'b0);
    enc_step(1'b1, 1'b1, 1'b0);
    enc_step(1'b1, 1'b0, 1'b1);
    chk_word(d1, 16'h9234);
    chk_word(d2, 16'h7edc);
    wr(ADDR_POWER, 8'h01);
    chk_word({14'h0, pd}, 16'h0001);
    enc_step(1'b0, 1'b0, 1'b0);
    enc_step(1'b1, 1'b0, 1'b0);
    wr(ADDR_POWER, 8'h00);
    $display("test encode done");
  endtask
  task automatic t_parallel();
    strap = 1'b1;
    u_host.set_pins(1'b1, 1'b1, 1'b1);
    sdo_drv = 1'b0;
    u_host.wait_clk(6);
    chk_flag(ser, 1'b0);
    chk_flag(dcs, 1'b1);
    chk_flag(twos, 1'b1);
    chk_word({14'h0, pd}, 16'h0002);
    u_host.set_pins(1'b0, 1'b0, 1'b0);
    sdo_drv = 1'b1;
    u_host.wait_clk(6);
    chk_flag(dcs, 1'b0);
    chk_flag(twos, 1'b0);
    chk_word({14'h0, pd}, 16'h0001);
    $display("test parallel done");
  endtask
  // Main sequence
  initial begin
    // Idle levels at time zero, reset asserted
    reset   = 1'b1;
    strap   = 1'b0;
    enc_p   = 1'b0;
    enc_n   = 1'b0;
    sdo_drv = 1'b1;
    c1      = 16'h0000;
    c2      = 16'h0000;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    u_host.wait_clk(4);
    t_serial();
    t_abort();
    t_encode();
    t_parallel();
    conclude();
  end
endmodule
`default_nettype wire
